// *** tdgc_pkg.sv ***
// Constants, state types and shared helpers for the TCP test traffic
// generator and checker. Assumes a single clock for both halves.
// Functional notes
// - Go captures settings; transfer_active stays high throughout.
// - Packets use packet length; last takes remainder.
// - Incrementing 32-bit pattern, realigned by byte offset.
// - Each packet queues its checksum and length.
// - Almost-full payload queue stalls writes, data holds.
// - Last word written enters checksum wait.
// - Info written four cycles later; total reduced.
// - Next packet waits for info queue space.
// - Zero remaining: drain payload, then go idle.
// - Info read; four cycles later outputs load.
// - Payload queue head is valid before acknowledge.
// - Valid holds whole packet; not ready holds data.
// - Counter at two with acknowledge raises last.
// - Last word byte enable from length; others full.
// - Accepted last word drops valid, rechecks queue.
// - Error at end of packet sets flag, latches code.
// - Count enabled bytes of every received word.
// - Good packets snapshot count; reload before next.
// - Size clear zeroes the received byte counter.
// - Expected word from count bits 33 to 0.
// - First mismatch in good packet latches fail data.
package tdgc_pkg;
    localparam int LEN_W = 11;
    localparam int TOT_W = 32;
    localparam int ERR_W = 8;
    localparam int CNT_W = 48;
    localparam int WL_W = 10;
    // Packet info is queued only after a packet's last word, so the payload
    // queue must hold a whole maximum-length packet or the two sides lock.
    localparam int PQ_DEPTH = 1024;
    localparam int PQ_AW = 10;
    localparam logic [PQ_AW:0] PQ_AFULL = 11'h3fd;
    localparam int IQ_DEPTH = 4;
    localparam int IQ_AW = 2;
    localparam int IQ_W = 27;
    localparam logic [IQ_AW:0] IQ_FULL = 3'h4;
    localparam int CSUM_LAT = 4;
    localparam int INFO_LAT = 2;
    localparam logic [3:0] BE_ALL = 4'hf;

    typedef enum logic [5:0] {
        gen_idle            = 6'h01,
        gen_check_len       = 6'h02,
        gen_load_size       = 6'h04,
        gen_data            = 6'h08,
        checksum_wait_state = 6'h10,
        gen_drain           = 6'h20
    } tdgc_gen_e;

    typedef enum logic [2:0] {
        queue_check_state = 3'h1,
        rd_info           = 3'h2,
        rd_xfer           = 3'h4
    } tdgc_rd_e;

    // Word at a byte position of the little-endian incrementing stream.
    function automatic logic [31:0] tdgc_align(input logic [33:0] pos);
        logic [63:0] pair;
        pair = {pos[33:2] + 32'h0000_0001, pos[33:2]};
        pair = pair >> {pos[1:0], 3'h0};
        return pair[31:0];
    endfunction

    function automatic logic [31:0] tdgc_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic [3:0] tdgc_last_be(input logic [1:0] len);
        return (len == 2'h0) ? BE_ALL : 4'(BE_ALL >> (3'h4 - 3'(len)));
    endfunction

    function automatic logic [WL_W-1:0] tdgc_words(
        input logic [LEN_W-1:0] len);
        logic [LEN_W:0] s;
        s = {1'b0, len} + 12'h003;
        return s[LEN_W:2];
    endfunction
endpackage

// *** tdgc_top.sv ***
// Test traffic generator and receive checker for a TCP offload engine.
// Assumes the engine's transmit and receive ports share clk.
`timescale 1ns/1ns
`default_nettype none
module tdgc_top
    import tdgc_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             soft_reset,
    input  wire logic             transfer_go,
    input  wire logic [TOT_W-1:0] total_length_setting,
    input  wire logic [LEN_W-1:0] packet_length_setting,
    output var  logic             transfer_active,
    output var  logic [LEN_W-1:0] tx_packet_length,
    output var  logic [15:0]      tx_payload_checksum,
    output var  logic [31:0]      tx_word,
    output var  logic             tx_valid,
    input  wire logic             tx_ready,
    output var  logic             tx_last,
    output var  logic [3:0]       tx_byte_enable,
    input  wire logic [31:0]      rx_word,
    input  wire logic             rx_valid,
    input  wire logic             rx_last,
    input  wire logic [3:0]       rx_byte_enable,
    input  wire logic [ERR_W-1:0] rx_error_code,
    output var  logic             rx_error_flag,
    output var  logic [ERR_W-1:0] rx_error_latched,
    input  wire logic             rx_error_flag_clear,
    input  wire logic             check_enable,
    input  wire logic             size_clear,
    output var  logic             compare_fail,
    output var  logic [CNT_W-1:0] fail_byte_position,
    output var  logic [31:0]      fail_expected_word,
    output var  logic [31:0]      fail_received_word,
    output var  logic [CNT_W-1:0] rx_byte_counter
);
    // Generator state.
    tdgc_gen_e        gst_q, gst_d;
    logic [TOT_W-1:0] remaining_total_count_q, remaining_total_count_d;
    logic [LEN_W-1:0] psize_q, psize_d, cur_len_q, cur_len_d;
    logic [WL_W-1:0]  write_words_left_q, write_words_left_d;
    logic [33:0]      gpos_q, gpos_d;
    logic             pq_wen_q, pq_wen_d, active_q, active_d;
    logic [31:0]      pq_wdata_q, pq_wdata_d, acc_q, acc_d;
    logic [15:0]      csum_q, csum_d;
    logic [CSUM_LAT:0] checksum_done_pipe_q, checksum_done_pipe_d;
    logic [16:0]      fold;
    logic             wr_go;
    // Queue and transmit state.
    logic [31:0]      pq_mem [PQ_DEPTH];
    logic [IQ_W-1:0]  iq_mem [IQ_DEPTH];
    logic [PQ_AW-1:0] pw_q, pw_d, pr_q, pr_d;
    logic [PQ_AW:0]   pcnt_q, pcnt_d;
    logic             headv_q, headv_d, pafull_q, pafull_d;
    logic             pempty_q, pempty_d, take, pop;
    logic [31:0]      head_q, head_d;
    logic [IQ_AW-1:0] iw_q, iw_d, ir_q, ir_d;
    logic [IQ_AW:0]   icnt_q, icnt_d;
    logic             ifull_q, ifull_d, ipop;
    logic [IQ_W-1:0]  idata_q, idata_d;
    tdgc_rd_e         rst_q, rst_d;
    logic [INFO_LAT:0] info_read_pipe_q, info_read_pipe_d;
    logic [WL_W-1:0]  read_words_left_q, read_words_left_d;
    logic [LEN_W-1:0] tlen_q, tlen_d;
    logic [15:0]      tcs_q, tcs_d;
    logic             tval_q, tval_d, tlast_q, tlast_d;
    logic [3:0]       tbe_q, tbe_d;
    // Checker state.
    logic [CNT_W-1:0] rx_byte_counter_q, rx_byte_counter_d;
    logic [CNT_W-1:0] good_byte_snapshot_q, good_byte_snapshot_d, base;
    logic             inpkt_q, inpkt_d, eflag_q, eflag_d;
    logic [ERR_W-1:0] elat_q, elat_d;
    logic             fail_q, fail_d, pend_q, pend_d, mism, commit;
    logic [CNT_W-1:0] fpos_q, fpos_d;
    logic [31:0]      fexp_q, fexp_d, frcv_q, frcv_d, exp_w;

    // Writes are pipelined one cycle, so almost-full leaves headroom.
    assign wr_go = (gst_q == gen_data) && !pafull_q;

    always_comb begin
        fold = {1'b0, acc_q[15:0]} + {1'b0, acc_q[31:16]};
        gst_d = gst_q;
        remaining_total_count_d = remaining_total_count_q;
        psize_d = psize_q;
        cur_len_d = cur_len_q;
        write_words_left_d = write_words_left_q;
        gpos_d = gpos_q;
        active_d = active_q;
        pq_wen_d = wr_go;
        pq_wdata_d = pq_wdata_q;
        acc_d = pq_wen_q ? acc_q + {16'h0000, pq_wdata_q[15:0]}
                         + {16'h0000, pq_wdata_q[31:16]} : acc_q;
        csum_d = csum_q;
        checksum_done_pipe_d = {checksum_done_pipe_q[CSUM_LAT-1:0], 1'b0};
        if (checksum_done_pipe_q[CSUM_LAT-1]) begin
            csum_d = fold[15:0] + {15'h0000, fold[16]};
        end
        if (wr_go) begin
            // Unused tail bytes are zeroed so they never enter the sum.
            pq_wdata_d = tdgc_align(gpos_q) & tdgc_mask(
                (write_words_left_q == 10'h001) ?
                tdgc_last_be(cur_len_q[1:0]) : BE_ALL);
            gpos_d = gpos_q + (((write_words_left_q == 10'h001) &&
                     (cur_len_q[1:0] != 2'h0)) ?
                     {32'h0000_0000, cur_len_q[1:0]} : 34'h0_0000_0004);
            write_words_left_d = write_words_left_q - 10'h001;
        end
        case (gst_q)
            gen_idle: begin
                if (transfer_go) begin
                    remaining_total_count_d = total_length_setting;
                    psize_d = packet_length_setting;
                    active_d = 1'b1;
                    gpos_d = '0;
                    gst_d = gen_check_len;
                end
            end
            gen_check_len: begin
                if (remaining_total_count_q == '0) begin
                    gst_d = gen_drain;
                end else if (!ifull_q) begin
                    cur_len_d = (remaining_total_count_q <
                        {21'h00_0000, psize_q}) ?
                        remaining_total_count_q[LEN_W-1:0] : psize_q;
                    gst_d = gen_load_size;
                end
            end
            gen_load_size: begin
                write_words_left_d = tdgc_words(cur_len_q);
                acc_d = '0;
                gst_d = gen_data;
            end
            gen_data: begin
                if (wr_go && write_words_left_q == 10'h001) begin
                    checksum_done_pipe_d[0] = 1'b1;
                    gst_d = checksum_wait_state;
                end
            end
            checksum_wait_state: begin
                if (checksum_done_pipe_q[CSUM_LAT]) begin
                    remaining_total_count_d = remaining_total_count_q -
                        {21'h00_0000, cur_len_q};
                    gst_d = gen_check_len;
                end
            end
            gen_drain: begin
                if (pempty_q) begin
                    active_d = 1'b0;
                    gst_d = gen_idle;
                end
            end
            default: gst_d = gen_idle;
        endcase
        if (soft_reset) begin
            gst_d = gen_idle;
            active_d = 1'b0;
            pq_wen_d = 1'b0;
            checksum_done_pipe_d = '0;
            remaining_total_count_d = '0;
            write_words_left_d = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gst_q <= gen_idle;
            remaining_total_count_q <= '0;
            psize_q <= '0;
            cur_len_q <= '0;
            write_words_left_q <= '0;
            gpos_q <= '0;
            active_q <= 1'b0;
            pq_wen_q <= 1'b0;
            pq_wdata_q <= '0;
            acc_q <= '0;
            csum_q <= '0;
            checksum_done_pipe_q <= '0;
        end else begin
            gst_q <= gst_d;
            remaining_total_count_q <= remaining_total_count_d;
            psize_q <= psize_d;
            cur_len_q <= cur_len_d;
            write_words_left_q <= write_words_left_d;
            gpos_q <= gpos_d;
            active_q <= active_d;
            pq_wen_q <= pq_wen_d;
            pq_wdata_q <= pq_wdata_d;
            acc_q <= acc_d;
            csum_q <= csum_d;
            checksum_done_pipe_q <= checksum_done_pipe_d;
        end
    end

    // Queue storage needs no reset; pointers and counts define content.
    always_ff @(posedge clk) begin
        if (pq_wen_q) begin
            pq_mem[pw_q] <= pq_wdata_q;
        end
        if (checksum_done_pipe_q[CSUM_LAT]) begin
            iq_mem[iw_q] <= {csum_q, cur_len_q};
        end
    end

    assign pop = tval_q && tx_ready;
    // Head register makes the queue first-word-fall-through.
    assign take = (!headv_q || pop) && (pcnt_q != '0);
    assign ipop = (rst_q == queue_check_state) && (icnt_q != '0);

    always_comb begin
        pw_d = pq_wen_q ? pw_q + 10'h001 : pw_q;
        pr_d = take ? pr_q + 10'h001 : pr_q;
        pcnt_d = pcnt_q + {10'h000, pq_wen_q} - {10'h000, take};
        head_d = take ? pq_mem[pr_q] : head_q;
        headv_d = take | (headv_q & ~pop);
        iw_d = checksum_done_pipe_q[CSUM_LAT] ? iw_q + 2'h1 : iw_q;
        ir_d = ipop ? ir_q + 2'h1 : ir_q;
        icnt_d = icnt_q + {2'h0, checksum_done_pipe_q[CSUM_LAT]}
                 - {2'h0, ipop};
        idata_d = ipop ? iq_mem[ir_q] : idata_q;
        rst_d = rst_q;
        info_read_pipe_d = {info_read_pipe_q[INFO_LAT-1:0], ipop};
        read_words_left_d = read_words_left_q;
        tlen_d = tlen_q;
        tcs_d = tcs_q;
        tval_d = tval_q;
        tlast_d = tlast_q;
        tbe_d = tbe_q;
        case (rst_q)
            queue_check_state: begin
                if (ipop) begin
                    rst_d = rd_info;
                end
            end
            rd_info: begin
                if (info_read_pipe_q[INFO_LAT]) begin
                    tlen_d = idata_q[LEN_W-1:0];
                    tcs_d = idata_q[IQ_W-1:LEN_W];
                    read_words_left_d = tdgc_words(idata_q[LEN_W-1:0]);
                    tval_d = 1'b1;
                    tlast_d = (read_words_left_d == 10'h001);
                    tbe_d = tlast_d ? tdgc_last_be(idata_q[1:0]) : BE_ALL;
                    rst_d = rd_xfer;
                end
            end
            rd_xfer: begin
                if (pop) begin
                    read_words_left_d = read_words_left_q - 10'h001;
                    if (tlast_q) begin
                        tval_d = 1'b0;
                        tlast_d = 1'b0;
                        tbe_d = BE_ALL;
                        rst_d = queue_check_state;
                    end else if (read_words_left_q == 10'h002) begin
                        tlast_d = 1'b1;
                        tbe_d = tdgc_last_be(tlen_q[1:0]);
                    end
                end
            end
            default: rst_d = queue_check_state;
        endcase
        if (soft_reset) begin
            pw_d = '0;
            pr_d = '0;
            pcnt_d = '0;
            headv_d = 1'b0;
            iw_d = '0;
            ir_d = '0;
            icnt_d = '0;
            rst_d = queue_check_state;
            info_read_pipe_d = '0;
            tval_d = 1'b0;
            tlast_d = 1'b0;
            tbe_d = BE_ALL;
        end
        pafull_d = (pcnt_d >= PQ_AFULL);
        pempty_d = !headv_d && (pcnt_d == '0);
        ifull_d = (icnt_d == IQ_FULL);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pw_q <= '0;
            pr_q <= '0;
            pcnt_q <= '0;
            head_q <= '0;
            headv_q <= 1'b0;
            pafull_q <= 1'b0;
            pempty_q <= 1'b1;
            iw_q <= '0;
            ir_q <= '0;
            icnt_q <= '0;
            ifull_q <= 1'b0;
            idata_q <= '0;
            rst_q <= queue_check_state;
            info_read_pipe_q <= '0;
            read_words_left_q <= '0;
            tlen_q <= '0;
            tcs_q <= '0;
            tval_q <= 1'b0;
            tlast_q <= 1'b0;
            tbe_q <= BE_ALL;
        end else begin
            pw_q <= pw_d;
            pr_q <= pr_d;
            pcnt_q <= pcnt_d;
            head_q <= head_d;
            headv_q <= headv_d;
            pafull_q <= pafull_d;
            pempty_q <= pempty_d;
            iw_q <= iw_d;
            ir_q <= ir_d;
            icnt_q <= icnt_d;
            ifull_q <= ifull_d;
            idata_q <= idata_d;
            rst_q <= rst_d;
            info_read_pipe_q <= info_read_pipe_d;
            read_words_left_q <= read_words_left_d;
            tlen_q <= tlen_d;
            tcs_q <= tcs_d;
            tval_q <= tval_d;
            tlast_q <= tlast_d;
            tbe_q <= tbe_d;
        end
    end

    // Reloading from the snapshot discards bytes of a packet that ended with an error code.
    assign base = inpkt_q ? rx_byte_counter_q
                          : good_byte_snapshot_q;
    assign exp_w = tdgc_align(base[33:0]);
    assign mism = check_enable && rx_valid &&
                  (((exp_w ^ rx_word) & tdgc_mask(rx_byte_enable)) != '0);
    assign commit = rx_valid && rx_last && (rx_error_code == '0) &&
                    !fail_q && (pend_q || mism);

    always_comb begin
        rx_byte_counter_d = rx_byte_counter_q;
        good_byte_snapshot_d = good_byte_snapshot_q;
        inpkt_d = inpkt_q;
        elat_d = elat_q;
        fail_d = fail_q | commit;
        pend_d = pend_q;
        fpos_d = fpos_q;
        fexp_d = fexp_q;
        frcv_d = frcv_q;
        eflag_d = eflag_q & ~rx_error_flag_clear;
        if (rx_valid) begin
            rx_byte_counter_d = base + {47'h0, rx_byte_enable[0]}
                + {47'h0, rx_byte_enable[1]} + {47'h0, rx_byte_enable[2]}
                + {47'h0, rx_byte_enable[3]};
            inpkt_d = !rx_last;
            if (mism && !fail_q && !pend_q) begin
                pend_d = 1'b1;
                fpos_d = base;
                fexp_d = exp_w;
                frcv_d = rx_word;
            end
            if (rx_last) begin
                pend_d = 1'b0;
                if (rx_error_code != '0) begin
                    eflag_d = 1'b1;
                    elat_d = rx_error_code;
                end else begin
                    good_byte_snapshot_d = rx_byte_counter_d;
                end
            end
        end
        if (size_clear || soft_reset) begin
            rx_byte_counter_d = '0;
            good_byte_snapshot_d = '0;
            inpkt_d = 1'b0;
            fail_d = commit && !soft_reset;
            pend_d = 1'b0;
        end
        if (soft_reset) begin
            eflag_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_byte_counter_q <= '0;
            good_byte_snapshot_q <= '0;
            inpkt_q <= 1'b0;
            eflag_q <= 1'b0;
            elat_q <= '0;
            fail_q <= 1'b0;
            pend_q <= 1'b0;
            fpos_q <= '0;
            fexp_q <= '0;
            frcv_q <= '0;
        end else begin
            rx_byte_counter_q <= rx_byte_counter_d;
            good_byte_snapshot_q <= good_byte_snapshot_d;
            inpkt_q <= inpkt_d;
            eflag_q <= eflag_d;
            elat_q <= elat_d;
            fail_q <= fail_d;
            pend_q <= pend_d;
            fpos_q <= fpos_d;
            fexp_q <= fexp_d;
            frcv_q <= frcv_d;
        end
    end

    assign transfer_active = active_q;
    assign tx_packet_length = tlen_q;
    assign tx_payload_checksum = tcs_q;
    assign tx_word = head_q;
    assign tx_valid = tval_q;
    assign tx_last = tlast_q;
    assign tx_byte_enable = tbe_q;
    assign rx_error_flag = eflag_q;
    assign rx_error_latched = elat_q;
    assign compare_fail = fail_q;
    assign fail_byte_position = fpos_q;
    assign fail_expected_word = fexp_q;
    assign fail_received_word = frcv_q;
    assign rx_byte_counter = rx_byte_counter_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b || soft_reset);

    go_active_a: assert property (
        gst_q == gen_idle && transfer_go |=> transfer_active)
        else $error("go did not raise transfer_active");
    stall_a: assert property (
        gst_q == gen_data && pafull_q |=> !pq_wen_q)
        else $error("payload written while almost full");
    csum_enter_a: assert property (
        $rose(checksum_done_pipe_q[0]) |-> gst_q == checksum_wait_state)
        else $error("checksum wait not entered");
    info_four_a: assert property (
        checksum_done_pipe_q[0] |-> ##4 checksum_done_pipe_q[CSUM_LAT]
        ##1 gst_q == gen_check_len)
        else $error("packet info not written four cycles later");
    info_load_a: assert property (
        ipop |-> ##4 (tx_valid && tx_packet_length == idata_q[LEN_W-1:0]
        && tx_payload_checksum == idata_q[IQ_W-1:LEN_W]))
        else $error("packet info not presented");
    tx_hold_a: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_word))
        else $error("transmit word changed while stalled");
    full_be_a: assert property (
        tx_valid && !tx_last |-> tx_byte_enable == BE_ALL)
        else $error("non-final word without full byte enable");
    last_drop_a: assert property (
        tx_valid && tx_last && tx_ready |=> !tx_valid)
        else $error("valid held after final word");
    err_flag_a: assert property (
        rx_valid && rx_last && rx_error_code != '0 |=>
        rx_error_flag && rx_error_latched == $past(rx_error_code))
        else $error("receive error not flagged");
    size_zero_a: assert property (
        size_clear |=> rx_byte_counter == '0)
        else $error("size clear left a count");
    fail_keep_a: assert property (
        compare_fail && !size_clear |=>
        compare_fail && $stable(fail_byte_position))
        else $error("first mismatch not held");
    drain_idle_a: assert property (
        gst_q == gen_drain && pempty_q |=> !transfer_active)
        else $error("transfer_active held after drain");

    pkt_sent_c: cover property (tx_valid && tx_last && tx_ready);
    stall_c: cover property (tx_valid && !tx_ready ##1 tx_ready);
    fail_c: cover property ($rose(compare_fail));
    done_c: cover property ($fell(transfer_active));
endmodule // tdgc_top
`default_nettype wire

// *** tdgc_engine_model.sv ***
// Behavioural offload engine: stalls transmit and loops words back.
// Assumes it shares clk with the generator and checker.
`timescale 1ns/1ns
`default_nettype none
module tdgc_engine_model (
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic [7:0]  err_code,
    input  wire logic [31:0] tx_word,
    input  wire logic        tx_valid,
    input  wire logic        tx_last,
    input  wire logic [3:0]  tx_byte_enable,
    output var  logic        tx_ready,
    output var  logic [31:0] rx_word,
    output var  logic        rx_valid,
    output var  logic        rx_last,
    output var  logic [3:0]  rx_byte_enable,
    output var  logic [7:0]  rx_error_code
);
    logic [1:0] ph_q;
    logic       acc;
    assign acc = tx_valid && tx_ready;
    initial begin
        ph_q = 2'h0;
        {tx_ready, rx_valid, rx_last, rx_byte_enable} = 7'h00;
        {rx_word, rx_error_code} = 40'h00_0000_0000;
    end
    always @(posedge clk) begin
        ph_q <= ph_q + 2'h1;
        tx_ready <= !slow || ph_q[1];
        rx_valid <= acc;
        rx_last <= acc && tx_last;
        // Idle data is scrambled so a stale word never passes as valid.
        rx_word <= acc ? tx_word : ~rx_word;
        rx_byte_enable <= acc ? tx_byte_enable : 4'h0;
        rx_error_code <= (acc && tx_last) ? err_code : 8'h00;
    end
endmodule // tdgc_engine_model
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for tdgc_top looped back through an engine model.
// Assumes one 20 MHz clock for every port.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import tdgc_pkg::*;
    logic clk = 0, rst_b = 0, soft_reset = 0, transfer_go = 0, slow = 0;
    logic rx_error_flag_clear = 0, check_enable = 1, size_clear = 0;
    logic [31:0] total_length_setting = 32'h0000_0000;
    logic [10:0] packet_length_setting = 11'h001;
    logic [7:0] err_code = 8'h00;
    logic transfer_active, tx_valid, tx_ready, tx_last, rx_valid, rx_last;
    logic rx_error_flag, compare_fail;
    logic [10:0] tx_packet_length;
    logic [15:0] tx_payload_checksum;
    logic [31:0] tx_word, rx_word, fail_expected_word, fail_received_word;
    logic [3:0] tx_byte_enable, rx_byte_enable;
    logic [7:0] rx_error_code, rx_error_latched;
    logic [47:0] fail_byte_position, rx_byte_counter;
    int fails = 0, tests_run = 0, cyc = 0, nw = 0, bp = 0;
    logic [31:0] rem = 32'h0000_0000, cs = 32'h0000_0000, ew;
    logic [10:0] plen = 11'h001;
    logic [31:0] tot [5] = '{32'h0000_0010, 32'h0000_000d, 32'h0000_0007,
                             32'h0000_0025, 32'h0000_0200};
    logic [10:0] pl [5] = '{11'h008, 11'h005, 11'h003, 11'h00c, 11'h100};
    tdgc_top tdgc_top_inst (.*);
    tdgc_engine_model tdgc_engine_model_inst (.*);
    initial forever #25 clk = ~clk;
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic [31:0] pat(input int b, input logic [3:0] be);
        pat = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            pat[8*i +: 8] = be[i] ? 8'(((b + i) / 4) >> (8 * ((b + i) % 4)))
                : 8'h00;
        end
    endfunction
    task automatic run(input logic [31:0] t, input logic [10:0] p,
                       input logic c);
        int n;
        n = 0;
        rem = t;
        plen = p;
        bp = 0;
        @(posedge clk);
        size_clear <= c;
        transfer_go <= 1;
        total_length_setting <= t;
        packet_length_setting <= p;
        @(posedge clk);
        size_clear <= 0;
        transfer_go <= 0;
        @(posedge clk);
        #1 check(transfer_active, 1);
        while (transfer_active === 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        repeat (20) @(posedge clk);
        #1 check(transfer_active, 0);
        check(rem, 0);
    endtask
    // Every accepted word is judged against the length it travels with.
    always @(negedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            end_of_test();
        end
        if (tx_valid && tx_ready) begin
            nw++;
            ew = pat(bp, tx_byte_enable);
            check(tx_word, ew);
            cs = cs + ew[15:0] + ew[31:16];
            bp += $countones(tx_byte_enable);
            if (tx_last) begin
                check(tx_byte_enable, tx_packet_length[1:0] == 2'h0 ? 4'hf
                      : 4'(~(4'hf << tx_packet_length[1:0])));
                check(nw, (tx_packet_length + 12'h003) >> 2);
                check(tx_packet_length, rem < plen ? rem : plen);
                cs = cs[15:0] + cs[31:16];
                cs = cs[15:0] + cs[31:16];
                check(tx_payload_checksum, cs[15:0]);
                rem = rem - tx_packet_length;
                nw = 0;
                cs = 0;
            end else check(tx_byte_enable, 4'hf);
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1;
        #1 check(transfer_active, 0);
        for (int i = 0; i < 5; i++) begin
            slow <= i[0];
            run(tot[i], pl[i], 1'h1);
            check(rx_byte_counter, tot[i]);
            check(compare_fail, 0);
            check(rx_error_flag, 0);
        end
        run(32'h0000_0008, 11'h004, 1'h0);
        check(compare_fail, 1);
        check(fail_byte_position, 48'h0000_0000_0200);
        check(fail_expected_word, 32'h0000_0080);
        check(fail_received_word, 32'h0000_0000);
        err_code <= 8'h5a;
        run(32'h0000_0008, 11'h004, 1'h1);
        check(rx_error_flag, 1);
        check(rx_error_latched, 8'h5a);
        check(rx_byte_counter, 4);
        check(compare_fail, 0);
        @(posedge clk);
        rx_error_flag_clear <= 1;
        size_clear <= 1;
        @(posedge clk);
        rx_error_flag_clear <= 0;
        size_clear <= 0;
        @(posedge clk);
        #1 check(rx_error_flag, 0);
        check(rx_byte_counter, 0);
        rem = 32'h0000_0008;
        bp = 0;
        @(posedge clk);
        transfer_go <= 1;
        @(posedge clk);
        transfer_go <= 0;
        repeat (30) @(posedge clk);
        soft_reset <= 1;
        @(posedge clk);
        soft_reset <= 0;
        @(posedge clk);
        #1 check(transfer_active, 0);
        check(tx_valid, 0);
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
